// *** logic/rfd_pkg.sv ***
// shared constants, types and helpers of the format decoder
`default_nettype none
package rfd_pkg;
    localparam int INST_W = 32;
    localparam int DATA_W = 64;
    localparam int OPC_W = 6;
    localparam int REG_W = 5;
    localparam int DISP_W = 16;
    localparam int BDISP_W = 21;
    localparam int SHAMT_W = 6;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int FIRST_HI = 25;
    localparam int FIRST_LO = 21;
    localparam int BASE_HI = 20;
    localparam int BASE_LO = 16;
    localparam int DISP_HI = 15;
    localparam int DISP_LO = 0;
    localparam int BDISP_HI = 20;
    localparam int HIGH_SHIFT = 16;
    localparam int BR_SHIFT = 2;
    localparam logic [REG_W-1:0] REG_ZERO = 5'h1F;
    localparam logic [DATA_W-1:0] ZERO64 = 64'h0;
    localparam logic [DISP_W-1:0] ZERO16 = 16'h0;
    // opcode map
    localparam logic [OPC_W-1:0] OPC_PAL = 6'h00;
    localparam logic [OPC_W-1:0] OPC_ADDR_HIGH = 6'h09;
    localparam logic [OPC_W-1:0] OPC_INT_FIRST = 6'h10;
    localparam logic [OPC_W-1:0] OPC_INT_LAST = 6'h13;
    localparam logic [OPC_W-1:0] OPC_FP_FIRST = 6'h14;
    localparam logic [OPC_W-1:0] OPC_FP_LAST = 6'h17;
    localparam logic [OPC_W-1:0] OPC_MISC = 6'h18;
    localparam logic [OPC_W-1:0] OPC_JUMP = 6'h1A;
    localparam logic [OPC_W-1:0] OPC_BR_FIRST = 6'h30;
    localparam logic [OPC_W-1:0] OPC_FBR_FIRST = 6'h31;
    localparam logic [OPC_W-1:0] OPC_FBR_LAST = 6'h37;

    typedef enum logic [2:0] {FMT_MEM, FMT_BRANCH, FMT_OPER, FMT_FPOPER, FMT_PAL} rfd_fmt_t;
    typedef enum logic [3:0] {
        REL_LT, REL_LESS_UNSIGNED, REL_LE, REL_LESS_EQUAL_UNSIGNED, REL_EQ, REL_NE,
        REL_GE, REL_GREATER_EQUAL_UNSIGNED, REL_GT, REL_GREATER_UNSIGNED,
        REL_LOW_BIT_ZERO_TEST, REL_LOW_BIT_ONE_TEST
    } rfd_rel_t;
    localparam int REL_N = 12;

    function automatic logic [DATA_W-1:0] sign_extend(input logic [DATA_W-1:0] x, input int w);
        logic [DATA_W-1:0] r;
        r = x;
        for (int i = 0; i < DATA_W; i++) begin
            if (i >= w) begin
                r[i] = x[w-1];
            end
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] zero_extend(input logic [DATA_W-1:0] x, input int w);
        logic [DATA_W-1:0] r;
        r = x;
        for (int i = 0; i < DATA_W; i++) begin
            if (i >= w) begin
                r[i] = 1'b0;
            end
        end
        return r;
    endfunction

    function automatic rfd_fmt_t classify(input logic [OPC_W-1:0] opc);
        rfd_fmt_t f;
        f = FMT_MEM;
        if (opc == OPC_PAL) begin
            f = FMT_PAL;
        end else if (opc >= OPC_BR_FIRST) begin
            f = FMT_BRANCH;
        end else if (opc >= OPC_INT_FIRST && opc <= OPC_INT_LAST) begin
            f = FMT_OPER;
        end else if (opc >= OPC_FP_FIRST && opc <= OPC_FP_LAST) begin
            f = FMT_FPOPER;
        end
        return f;
    endfunction
endpackage
`default_nettype wire

// *** logic/rfd_cmp.sv ***
// relational unit: integer and floating comparisons of two operands
`default_nettype none
module rfd_cmp
    import rfd_pkg::*;
(
    input wire logic [rfd_pkg::DATA_W-1:0] a_i,
    input wire logic [rfd_pkg::DATA_W-1:0] b_i,
    input wire logic fp_i,
    output logic [rfd_pkg::REL_N-1:0] rel_o
);
    logic [DATA_W-1:0] ka;
    logic [DATA_W-1:0] kb;
    logic s_lt;
    logic s_eq;
    logic u_lt;
    logic u_eq;

    // floating keys: sign-magnitude mapped to unsigned order, both zeros equal
    function automatic logic [DATA_W-1:0] fkey(input logic [DATA_W-1:0] x);
        logic [DATA_W-1:0] k;
        k = {1'b1, x[DATA_W-2:0]};
        if (x[DATA_W-2:0] == ZERO64[DATA_W-2:0]) begin
            k = {1'b1, ZERO64[DATA_W-2:0]};
        end else if (x[DATA_W-1]) begin
            k = ~x;
        end
        return k;
    endfunction

    always_comb begin
        ka = fkey(a_i);
        kb = fkey(b_i);
        u_lt = a_i < b_i;
        u_eq = a_i == b_i;
        // operand type picks integer or floating meaning
        if (fp_i) begin
            s_lt = ka < kb;
            s_eq = ka == kb;
        end else begin
            s_lt = $signed(a_i) < $signed(b_i);
            s_eq = u_eq;
        end
        rel_o = '0;
        rel_o[REL_LT] = s_lt;
        rel_o[REL_LE] = s_lt | s_eq;
        rel_o[REL_EQ] = s_eq;
        rel_o[REL_NE] = ~s_eq;
        rel_o[REL_GE] = ~s_lt;
        rel_o[REL_GT] = ~s_lt & ~s_eq;
        rel_o[REL_LESS_UNSIGNED] = u_lt;
        rel_o[REL_LESS_EQUAL_UNSIGNED] = u_lt | u_eq;
        rel_o[REL_GREATER_EQUAL_UNSIGNED] = ~u_lt;
        rel_o[REL_GREATER_UNSIGNED] = ~u_lt & ~u_eq;
        rel_o[REL_LOW_BIT_ZERO_TEST] = ~a_i[0];
        rel_o[REL_LOW_BIT_ONE_TEST] = a_i[0];
    end
endmodule
`default_nettype wire

// *** logic/rfd_decode.sv ***
// instruction format decoder, address generator and helper operations
// What this block does
// - every instruction is 32 bits; major opcode sits in bits 31 to 26.
// - each instruction is sorted into memory, branch, operate, float operate, library call.
// - memory format yields opcode, first field, base field, 16-bit signed displacement.
// - effective address is base value plus sign-extended displacement, overflow dropped.
// - load_address_high scales displacement by 65536 before sign extension.
// - miscellaneous memory instructions read bits 15 to 0 as function code.
// - computed jump displacement goes to prediction as a hint and also into the effective address.
// - branch format yields opcode, one register field, 21-bit signed word displacement.
// - branch target is updated pc plus four times sign-extended displacement.
// - compare gives signed, unsigned, equality and low bit relations.
// - branch test is true when the register bears the relation to zero.
// - signed and equality comparisons are integer for quadwords and floating for float operands.
// - conditional store happens only while lock is set, and clears it unless a locked load arrives in the same cycle.
// - logical right shift fills with zeros and drops bits shifted out.
// - sign_extend copies top bit upward; zero_extend fills with zeros.
// - locked load records its physical address and sets the lock.
// - a source field of 31 supplies zero instead of register contents.
`default_nettype none
module rfd_decode
    import rfd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic inst_valid_i,
    input wire logic [rfd_pkg::INST_W-1:0] inst_i,
    input wire logic [rfd_pkg::DATA_W-1:0] pc_i,
    input wire logic [rfd_pkg::DATA_W-1:0] base_val_i,
    input wire logic [rfd_pkg::DATA_W-1:0] test_val_i,
    input wire rfd_pkg::rfd_rel_t br_rel_i,
    input wire logic [rfd_pkg::DATA_W-1:0] cmp_a_i,
    input wire logic [rfd_pkg::DATA_W-1:0] cmp_b_i,
    input wire logic cmp_fp_i,
    input wire rfd_pkg::rfd_rel_t cmp_rel_i,
    input wire logic [rfd_pkg::DATA_W-1:0] shift_val_i,
    input wire logic [rfd_pkg::SHAMT_W-1:0] shift_amt_i,
    input wire logic lock_load_i,
    input wire logic [rfd_pkg::DATA_W-1:0] lock_pa_i,
    input wire logic st_cond_i,
    output logic out_valid_o,
    output logic [rfd_pkg::OPC_W-1:0] opcode_o,
    output rfd_pkg::rfd_fmt_t format_o,
    output logic [rfd_pkg::REG_W-1:0] first_reg_field_o,
    output logic [rfd_pkg::REG_W-1:0] base_reg_field_o,
    output logic [rfd_pkg::DISP_W-1:0] disp_o,
    output logic func_valid_o,
    output logic [rfd_pkg::DISP_W-1:0] func_o,
    output logic hint_valid_o,
    output logic [rfd_pkg::DISP_W-1:0] hint_o,
    output logic [rfd_pkg::BDISP_W-1:0] br_disp_o,
    output logic [rfd_pkg::DATA_W-1:0] mem_va_o,
    output logic [rfd_pkg::DATA_W-1:0] br_target_o,
    output logic br_taken_o,
    output logic cmp_res_o,
    output logic [rfd_pkg::DATA_W-1:0] shr_o,
    output logic lock_flag_o,
    output logic [rfd_pkg::DATA_W-1:0] lock_addr_o,
    output logic sc_ok_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // field split
    logic [OPC_W-1:0] opc;
    logic [REG_W-1:0] first_fld;
    logic [REG_W-1:0] base_fld;
    logic [DISP_W-1:0] disp;
    logic [BDISP_W-1:0] bdisp;
    rfd_fmt_t fmt;
    logic [DATA_W-1:0] base_opnd;
    logic [DATA_W-1:0] test_opnd;
    logic br_fp;
    logic [REL_N-1:0] test_rel;
    logic [REL_N-1:0] gen_rel;

    always_comb begin
        opc = inst_i[OPC_HI:OPC_LO];
        first_fld = inst_i[FIRST_HI:FIRST_LO];
        base_fld = inst_i[BASE_HI:BASE_LO];
        disp = inst_i[DISP_HI:DISP_LO];
        bdisp = inst_i[BDISP_HI:DISP_LO];
        fmt = classify(opc);
        // unused fields carry 31, which reads as zero
        base_opnd = (base_fld == REG_ZERO) ? ZERO64 : base_val_i;
        test_opnd = (first_fld == REG_ZERO) ? ZERO64 : test_val_i;
        br_fp = (opc >= OPC_FBR_FIRST) && (opc <= OPC_FBR_LAST);
    end

    rfd_cmp u_test (
        .a_i(test_opnd),
        .b_i(ZERO64),
        .fp_i(br_fp),
        .rel_o(test_rel)
    );

    rfd_cmp u_gen (
        .a_i(cmp_a_i),
        .b_i(cmp_b_i),
        .fp_i(cmp_fp_i),
        .rel_o(gen_rel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decode registers
    logic valid_r, valid_nxt;
    logic [OPC_W-1:0] opc_r, opc_nxt;
    rfd_fmt_t fmt_r, fmt_nxt;
    logic [REG_W-1:0] first_fld_r, first_fld_nxt;
    logic [REG_W-1:0] base_fld_r, base_fld_nxt;
    logic [DISP_W-1:0] disp_r, disp_nxt;
    logic fv_r, fv_nxt;
    logic [DISP_W-1:0] func_r, func_nxt;
    logic hv_r, hv_nxt;
    logic [DISP_W-1:0] hint_r, hint_nxt;
    logic [BDISP_W-1:0] bd_r, bd_nxt;
    logic [DATA_W-1:0] va_r, va_nxt;
    logic [DATA_W-1:0] tgt_r, tgt_nxt;
    logic tk_r, tk_nxt;

    always_comb begin
        valid_nxt = inst_valid_i;
        opc_nxt = opc_r;
        fmt_nxt = fmt_r;
        first_fld_nxt = first_fld_r;
        base_fld_nxt = base_fld_r;
        disp_nxt = disp_r;
        func_nxt = func_r;
        hint_nxt = hint_r;
        bd_nxt = bd_r;
        va_nxt = va_r;
        tgt_nxt = tgt_r;
        fv_nxt = 1'b0;
        hv_nxt = 1'b0;
        tk_nxt = 1'b0;
        if (inst_valid_i) begin
            opc_nxt = opc;
            fmt_nxt = fmt;
            first_fld_nxt = first_fld;
            base_fld_nxt = base_fld;
            disp_nxt = disp;
            bd_nxt = bdisp;
            // function code also feeds mem_va_o as a sign-extended displacement, as any memory displacement does
            fv_nxt = (fmt == FMT_MEM) && (opc == OPC_MISC);
            func_nxt = disp;
            // jump displacement is a prediction hint and also a term of the effective address
            hv_nxt = (fmt == FMT_MEM) && (opc == OPC_JUMP);
            hint_nxt = disp;
            if (opc == OPC_ADDR_HIGH) begin
                va_nxt = base_opnd + sign_extend({ZERO64[DATA_W-1:DISP_W+HIGH_SHIFT], disp,
                    ZERO16}, DISP_W + HIGH_SHIFT);
            end else begin
                va_nxt = base_opnd + sign_extend(zero_extend(64'(disp), DISP_W), DISP_W);
            end
            tgt_nxt = pc_i + sign_extend({ZERO64[DATA_W-1:BDISP_W+BR_SHIFT], bdisp,
                ZERO64[BR_SHIFT-1:0]}, BDISP_W + BR_SHIFT);
            tk_nxt = (fmt == FMT_BRANCH) && test_rel[br_rel_i];
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_r <= 1'b0;
            opc_r <= '0;
            fmt_r <= FMT_MEM;
            first_fld_r <= '0;
            base_fld_r <= '0;
            disp_r <= '0;
            fv_r <= 1'b0;
            func_r <= '0;
            hv_r <= 1'b0;
            hint_r <= '0;
            bd_r <= '0;
            va_r <= '0;
            tgt_r <= '0;
            tk_r <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
            opc_r <= opc_nxt;
            fmt_r <= fmt_nxt;
            first_fld_r <= first_fld_nxt;
            base_fld_r <= base_fld_nxt;
            disp_r <= disp_nxt;
            fv_r <= fv_nxt;
            func_r <= func_nxt;
            hv_r <= hv_nxt;
            hint_r <= hint_nxt;
            bd_r <= bd_nxt;
            va_r <= va_nxt;
            tgt_r <= tgt_nxt;
            tk_r <= tk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers and lock
    logic cmp_r, cmp_nxt;
    logic [DATA_W-1:0] shr_r, shr_nxt;
    logic lock_r, lock_nxt;
    logic [DATA_W-1:0] la_r, la_nxt;
    logic sc_r, sc_nxt;

    always_comb begin
        cmp_nxt = gen_rel[cmp_rel_i];
        shr_nxt = shift_val_i >> shift_amt_i;
        sc_nxt = st_cond_i && lock_r;
        lock_nxt = lock_r;
        la_nxt = la_r;
        if (sc_nxt) begin
            lock_nxt = 1'b0;
        end
        // a new locked load wins over a same-cycle clear
        if (lock_load_i) begin
            lock_nxt = 1'b1;
            la_nxt = lock_pa_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmp_r <= 1'b0;
            shr_r <= '0;
            lock_r <= 1'b0;
            la_r <= '0;
            sc_r <= 1'b0;
        end else begin
            cmp_r <= cmp_nxt;
            shr_r <= shr_nxt;
            lock_r <= lock_nxt;
            la_r <= la_nxt;
            sc_r <= sc_nxt;
        end
    end

    assign out_valid_o = valid_r;
    assign opcode_o = opc_r;
    assign format_o = fmt_r;
    assign first_reg_field_o = first_fld_r;
    assign base_reg_field_o = base_fld_r;
    assign disp_o = disp_r;
    assign func_valid_o = fv_r;
    assign func_o = func_r;
    assign hint_valid_o = hv_r;
    assign hint_o = hint_r;
    assign br_disp_o = bd_r;
    assign mem_va_o = va_r;
    assign br_target_o = tgt_r;
    assign br_taken_o = tk_r;
    assign cmp_res_o = cmp_r;
    assign shr_o = shr_r;
    assign lock_flag_o = lock_r;
    assign lock_addr_o = la_r;
    assign sc_ok_o = sc_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_locked_load;
        lock_load_i;
    endsequence
    sequence s_cond_store;
        st_cond_i && !lock_load_i;
    endsequence

    a_valid_follow: assert property (inst_valid_i |=> out_valid_o)
        else $error("valid did not follow instruction");
    a_opcode_top: assert property (inst_valid_i |=> opcode_o == $past(inst_i[31:26]))
        else $error("opcode not taken from top bits");
    a_va_plain_sum: assert property (inst_valid_i && inst_i[31:26] != 6'h09
        && inst_i[20:16] != 5'h1F |=> mem_va_o ==
        $past(base_val_i) + {{48{$past(inst_i[15])}}, $past(inst_i[15:0])})
        else $error("effective address wrong");
    a_addr_high_scale: assert property (inst_valid_i && inst_i[31:26] == 6'h09 |=>
        mem_va_o[15:0] == $past(base_opnd[15:0]))
        else $error("high address low half altered");
    a_zero_base: assert property (inst_valid_i && inst_i[20:16] == 5'h1F
        && inst_i[31:26] != 6'h09 |=> mem_va_o[15:0] == $past(inst_i[15:0]))
        else $error("base 31 did not read zero");
    a_branch_target: assert property (inst_valid_i |=> br_target_o ==
        $past(pc_i) + {{41{$past(inst_i[20])}}, $past(inst_i[20:0]), 2'b00})
        else $error("branch target wrong");
    a_hint_route: assert property (inst_valid_i && inst_i[31:26] == 6'h1A |=>
        hint_valid_o && hint_o == $past(inst_i[15:0]) && !func_valid_o)
        else $error("jump hint not routed");
    a_test_zero_eq: assert property (inst_valid_i && inst_i[31:26] >= 6'h30
        && inst_i[25:21] == 5'h1F && br_rel_i == REL_EQ |=> br_taken_o)
        else $error("zero register failed equal test");
    a_lock_sc_pair: assert property (s_locked_load ##1 s_cond_store |=>
        sc_ok_o && !lock_flag_o)
        else $error("conditional store after lock failed");
    a_sc_refused: assert property (st_cond_i && !lock_flag_o |=> !sc_ok_o)
        else $error("conditional store without lock");
    a_lock_record: assert property (lock_load_i |=> lock_flag_o
        && lock_addr_o == $past(lock_pa_i))
        else $error("locked load not recorded");
    a_shift_fill: assert property (shift_amt_i != 6'h00 |=>
        shr_o[63] == 1'b0 && shr_o == $past(shift_val_i) >> $past(shift_amt_i))
        else $error("right shift not zero filled");
endmodule
`default_nettype wire

// *** verif/rfd_decode_bench.sv ***
// self-checking bench of the format decoder
`default_nettype none
module rfd_decode_bench;
    import rfd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [31:0] inst;
        logic [63:0] pc;
        logic [63:0] base;
        logic [63:0] tv;
        rfd_rel_t rel;
        rfd_fmt_t fmt;
        logic tk;
    } rfd_row_t;

    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic inst_valid_i = 1'b0;
    logic [31:0] inst_i = 32'h0;
    logic [63:0] pc_i = 64'h0;
    logic [63:0] base_val_i = 64'h0;
    logic [63:0] test_val_i = 64'h0;
    rfd_rel_t br_rel_i = REL_EQ;
    logic [63:0] cmp_a_i = 64'h0;
    logic [63:0] cmp_b_i = 64'h0;
    logic cmp_fp_i = 1'b0;
    rfd_rel_t cmp_rel_i = REL_EQ;
    logic [63:0] shift_val_i = 64'h0;
    logic [5:0] shift_amt_i = 6'h0;
    logic lock_load_i = 1'b0;
    logic [63:0] lock_pa_i = 64'h0;
    logic st_cond_i = 1'b0;
    logic out_valid_o, func_valid_o, hint_valid_o, br_taken_o, cmp_res_o, lock_flag_o, sc_ok_o;
    logic [5:0] opcode_o;
    rfd_fmt_t format_o;
    logic [4:0] first_reg_field_o, base_reg_field_o;
    logic [15:0] disp_o, func_o, hint_o;
    logic [20:0] br_disp_o;
    logic [63:0] mem_va_o, br_target_o, shr_o, lock_addr_o;
    int mismatches = 0;
    int checks = 0;
    rfd_row_t rows [13];
    rfd_row_t r;
    logic [5:0] opc;
    logic [63:0] be, sx;

    always #12.5 ref_clk_i = ~ref_clk_i;

    rfd_decode rfd_decode_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .inst_valid_i(inst_valid_i),
        .inst_i(inst_i), .pc_i(pc_i), .base_val_i(base_val_i), .test_val_i(test_val_i),
        .br_rel_i(br_rel_i), .cmp_a_i(cmp_a_i), .cmp_b_i(cmp_b_i), .cmp_fp_i(cmp_fp_i),
        .cmp_rel_i(cmp_rel_i), .shift_val_i(shift_val_i), .shift_amt_i(shift_amt_i),
        .lock_load_i(lock_load_i), .lock_pa_i(lock_pa_i), .st_cond_i(st_cond_i),
        .out_valid_o(out_valid_o), .opcode_o(opcode_o), .format_o(format_o),
        .first_reg_field_o(first_reg_field_o), .base_reg_field_o(base_reg_field_o),
        .disp_o(disp_o), .func_valid_o(func_valid_o), .func_o(func_o),
        .hint_valid_o(hint_valid_o), .hint_o(hint_o), .br_disp_o(br_disp_o),
        .mem_va_o(mem_va_o), .br_target_o(br_target_o), .br_taken_o(br_taken_o),
        .cmp_res_o(cmp_res_o), .shr_o(shr_o), .lock_flag_o(lock_flag_o),
        .lock_addr_o(lock_addr_o), .sc_ok_o(sc_ok_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic step();
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    function automatic logic rel_ref(input logic [63:0] a, input logic [63:0] b, input rfd_rel_t k);
        case (k)
            REL_LT: return $signed(a) < $signed(b);
            REL_LESS_UNSIGNED: return a < b;
            REL_LE: return $signed(a) <= $signed(b);
            REL_LESS_EQUAL_UNSIGNED: return a <= b;
            REL_EQ: return a == b;
            REL_NE: return a != b;
            REL_GE: return $signed(a) >= $signed(b);
            REL_GREATER_EQUAL_UNSIGNED: return a >= b;
            REL_GT: return $signed(a) > $signed(b);
            REL_GREATER_UNSIGNED: return a > b;
            REL_LOW_BIT_ZERO_TEST: return !a[0];
            REL_LOW_BIT_ONE_TEST: return a[0];
            default: return 1'b0;
        endcase
    endfunction

    // compare and shift operands applied together, results one cycle later
    task automatic op(input logic [63:0] a, input logic [63:0] b, input logic fp,
        input rfd_rel_t k, input logic [5:0] amt, input logic exp);
        cmp_a_i = a;
        cmp_b_i = b;
        cmp_fp_i = fp;
        cmp_rel_i = k;
        shift_val_i = a;
        shift_amt_i = amt;
        step();
        chk(cmp_res_o, exp, "compare");
        chk(shr_o, a >> amt, "shift");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        // unused register fields carry 31
        rows[0] = '{{6'h08, 5'h01, 5'h02, 16'h8000}, 0, 64'h1000, 0, REL_EQ, FMT_MEM, 0};
        rows[1] = '{{6'h09, 5'h01, 5'h03, 16'hFFFF}, 0, 64'h10000, 0, REL_EQ, FMT_MEM, 0};
        rows[2] = '{{6'h28, 5'h01, 5'h04, 16'h0001}, 0, '1, 0, REL_EQ, FMT_MEM, 0};
        rows[3] = '{{6'h0B, 5'h01, 5'h1F, 16'h0010}, 0, 64'h1234, 0, REL_EQ, FMT_MEM, 0};
        rows[4] = '{{6'h18, 5'h1F, 5'h1F, 16'hC000}, 0, 0, 0, REL_EQ, FMT_MEM, 0};
        rows[5] = '{{6'h1A, 5'h1A, 5'h05, 16'h4001}, 0, 64'h800, 0, REL_EQ, FMT_MEM, 0};
        rows[6] = '{{6'h30, 5'h1F, 21'h100000}, 64'h100, 0, 64'h77, REL_EQ, FMT_BRANCH, 1};
        rows[7] = '{{6'h39, 5'h02, 21'h0FFFFF}, 64'h4000, 0, 64'h5, REL_LOW_BIT_ONE_TEST,
            FMT_BRANCH, 1};
        rows[8] = '{{6'h38, 5'h02, 21'h000001}, 64'h40, 0, -64'sd2, REL_GE, FMT_BRANCH, 0};
        rows[9] = '{{6'h10, 5'h01, 5'h02, 16'h0003}, 0, 0, 0, REL_EQ, FMT_OPER, 0};
        rows[10] = '{{6'h16, 5'h1F, 5'h02, 16'h0003}, 0, 0, 0, REL_EQ, FMT_FPOPER, 0};
        rows[11] = '{{6'h00, 26'h0}, 0, 0, 0, REL_EQ, FMT_PAL, 0};
        rows[12] = '{{6'h31, 5'h03, 21'h0}, 64'h8, 0, 64'h8000_0000_0000_0000, REL_EQ,
            FMT_BRANCH, 1};
        repeat (5) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(out_valid_o, 0, "reset valid");
        chk(format_o, FMT_MEM, "reset format");
        chk(lock_flag_o, 0, "reset lock");
        nrst_i = 1'b1;
        inst_valid_i = 1'b1;
        // back to back instructions, one every cycle
        foreach (rows[k]) begin
            r = rows[k];
            inst_i = r.inst;
            pc_i = r.pc;
            base_val_i = r.base;
            test_val_i = r.tv;
            br_rel_i = r.rel;
            step();
            opc = r.inst[31:26];
            chk(out_valid_o, 1, "valid");
            chk(opcode_o, opc, "opcode");
            chk(format_o, r.fmt, "format");
            chk(first_reg_field_o, r.inst[25:21], "first field");
            chk(br_taken_o, r.tk, "taken");
            chk(func_valid_o, opc == OPC_MISC, "func valid");
            chk(hint_valid_o, opc == OPC_JUMP, "hint valid");
            if (opc == OPC_MISC) chk(func_o, r.inst[15:0], "func");
            if (opc == OPC_JUMP) chk(hint_o, r.inst[15:0], "hint");
            if (r.fmt == FMT_BRANCH) begin
                chk(br_disp_o, r.inst[20:0], "branch disp");
                sx = {{41{r.inst[20]}}, r.inst[20:0], 2'b00};
                chk(br_target_o, r.pc + sx, "target");
            end else if (r.fmt == FMT_MEM && opc != OPC_MISC && opc != OPC_JUMP) begin
                chk(base_reg_field_o, r.inst[20:16], "base field");
                chk(disp_o, r.inst[15:0], "disp");
                be = (r.inst[20:16] == 5'h1F) ? 64'h0 : r.base;
                sx = {{48{r.inst[15]}}, r.inst[15:0]};
                if (opc == OPC_ADDR_HIGH) sx = {{32{r.inst[15]}}, r.inst[15:0], 16'h0};
                chk(mem_va_o, be + sx, "address");
            end
        end
        inst_valid_i = 1'b0;
        step();
        chk(out_valid_o, 0, "valid pulse");
        chk(br_taken_o, 0, "taken pulse");
        chk(opcode_o, 6'h31, "field hold");
        // every relation over signed, unsigned and low bit cases
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < REL_N; k++) begin
                be = (i == 0) ? 64'h5 : (i == 1) ? 64'h1 : 64'hFFFF_FFFF_FFFF_FFFE;
                sx = (i == 0) ? 64'h5 : (i == 1) ? '1 : 64'h3;
                op(be, sx, 1'b0, rfd_rel_t'(k), 6'(k * 5 + i * 4),
                    rel_ref(be, sx, rfd_rel_t'(k)));
            end
        end
        op(64'hBFF0_0000_0000_0000, 64'hC000_0000_0000_0000, 1'b1, REL_LT, 6'h3F, 0);
        op(64'hBFF0_0000_0000_0000, 64'hC000_0000_0000_0000, 1'b0, REL_LT, 6'h3F, 1);
        op(64'h0, 64'h8000_0000_0000_0000, 1'b1, REL_EQ, 6'h01, 1);
        // lock set, store performed, store refused, load beats store
        lock_load_i = 1'b1;
        lock_pa_i = 64'hABC0;
        step();
        lock_load_i = 1'b0;
        chk(lock_flag_o, 1, "lock set");
        chk(lock_addr_o, 64'hABC0, "lock addr");
        st_cond_i = 1'b1;
        step();
        chk(sc_ok_o, 1, "store done");
        chk(lock_flag_o, 0, "lock cleared");
        step();
        chk(sc_ok_o, 0, "store refused");
        st_cond_i = 1'b0;
        lock_load_i = 1'b1;
        step();
        st_cond_i = 1'b1;
        lock_pa_i = 64'h55;
        step();
        chk(sc_ok_o, 1, "store with load");
        chk(lock_flag_o, 1, "load wins");
        chk(lock_addr_o, 64'h55, "new addr");
        lock_load_i = 1'b0;
        st_cond_i = 1'b0;
        inst_valid_i = 1'b1;
        step();
        // reset in mid-run clears at once
        nrst_i = 1'b0;
        #1;
        chk(out_valid_o, 0, "mid reset valid");
        chk(lock_flag_o, 0, "mid reset lock");
        chk(mem_va_o, 0, "mid reset va");
        step();
        chk(out_valid_o, 0, "held in reset");
        // release with an instruction already waiting
        nrst_i = 1'b1;
        step();
        chk(out_valid_o, 1, "valid after reset");
        chk(opcode_o, 6'h31, "opcode after reset");
        chk(lock_flag_o, 0, "lock after reset");
        summarize();
    end
endmodule
`default_nettype wire
